// file: odb_debounce.v
`timescale 1ns/10ps
// Short-circuit debounce: 8 ticks per interval, tick = duration / 8
module odb_debounce #(
    parameter BASE_CYC = 10
) (
    // Clock and reset
    input  wire       i_clock,
    input  wire       i_rst,
    // Settings
    input  wire [2:0] i_code,
    input  wire [7:0] i_osc_scale,
    input  wire       i_use_osc,
    // Raw and filtered detection
    input  wire       i_short_raw,
    output reg        o_short
);
    reg  [15:0] pre;
    reg  [3:0]  ticks;
    wire [15:0] base_cyc;
    wire [15:0] tick_len;

    // Oscillator source: base period comes from measured scale
    assign base_cyc = i_use_osc ? {8'h00, i_osc_scale} : BASE_CYC[15:0];
    assign tick_len = base_cyc << (i_code - 3'h1);

    // Restart on any change of the raw level; qualify after 8 ticks
    always @(posedge i_clock) begin
        if (i_rst) begin
            pre     <= 16'h0000;
            ticks   <= 4'h0;
            o_short <= 1'b0;
        end else if (i_code == 3'h0) begin
            o_short <= i_short_raw;
            pre     <= 16'h0000;
            ticks   <= 4'h0;
        end else if (i_short_raw == o_short) begin
            pre     <= 16'h0000;
            ticks   <= 4'h0;
        end else if (pre + 16'h0001 >= tick_len) begin
            pre <= 16'h0000;
            if (ticks == 4'h7) begin
                o_short <= i_short_raw;
                ticks   <= 4'h0;
            end else begin
                ticks <= ticks + 4'h1;
            end
        end else begin
            pre <= pre + 16'h0001;
        end
    end
endmodule // odb_debounce

// file: odb_gain_ramp.v
`timescale 1ns/10ps
// Tracks a pending gain change and reports when it has been applied
module odb_gain_ramp #(
    parameter SETTLE = 16
) (
    // Clock and reset
    input  wire       i_clock,
    input  wire       i_rst,
    // Gain request
    input  wire       i_load,
    // Status
    output reg        o_applied
);
    reg  [7:0] count;

    // Load restarts the settle wait; load wins over completion
    always @(posedge i_clock) begin
        if (i_rst) begin
            count     <= 8'h00;
            o_applied <= 1'b0;
        end else if (i_load) begin
            count     <= SETTLE[7:0];
            o_applied <= 1'b0;
        end else if (count != 8'h00) begin
            count     <= count - 8'h01;
            o_applied <= (count == 8'h01);
        end else begin
            o_applied <= 1'b1;
        end
    end
endmodule // odb_gain_ramp

// file: odb_map.vh
`ifndef ODB_MAP_VH
`define ODB_MAP_VH
// Page select and register offsets
`define ODB_PAGE_OFS       8'h00
`define ODB_PAGE_ONE       8'h01
`define ODB_SPK_OFS        8'h2a
`define ODB_RSV2B_OFS      8'h2b
`define ODB_HP_OFS         8'h2c
`define ODB_RSV2D_OFS      8'h2d
`define ODB_MB_OFS         8'h2e
// Speaker driver control fields
`define ODB_SPK_GAIN_HI    4
`define ODB_SPK_GAIN_LO    3
`define ODB_SPK_UNMUTE     2
`define ODB_SPK_APPLIED    0
// Headphone driver control fields
`define ODB_HP_DEB_HI      7
`define ODB_HP_DEB_LO      5
`define ODB_HP_BIAS_HI     4
`define ODB_HP_BIAS_LO     3
`define ODB_HP_LINEOUT     2
`define ODB_HP_BIAS_RSV    2'h2
`define ODB_HP_BIAS_DEF    2'h0
// Mic bias fields
`define ODB_MB_SWPD        7
`define ODB_MB_FORCE       3
`define ODB_MB_LVL_HI      1
`define ODB_MB_LVL_LO      0
`define ODB_MB_LVL_OFF     2'h0
// Write masks: reserved bits are held at zero
`define ODB_SPK_WMASK      8'h1c
`define ODB_HP_WMASK       8'hfc
`define ODB_MB_WMASK       8'h8b
`define ODB_RESET_VAL      8'h00
// Debounce: clock rate in kHz, tick base in ns (8 us / 8 = 1 us)
`define ODB_CLK_KHZ        10000
`define ODB_TICK_BASE_NS   1000
`define ODB_TICKS_PER_DEB  8
`define ODB_GAIN_SETTLE    16
`endif

// file: odb_monitor.sv
`timescale 1ns/10ps
// Checks register port traffic against the driver control outputs
module odb_monitor (
    // Clock and reset
    input wire       i_clock,
    input wire       i_rst,
    // Register port
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    // Analog side and controls
    input wire       i_headset_det_en,
    input wire       i_headset_present,
    input wire       o_speaker_unmute,
    input wire [1:0] o_dac_bias_mode,
    input wire       o_headphone_output_lineout,
    input wire       o_sw_power_down,
    input wire [1:0] o_mic_bias_supply_level
);
    reg [7:0] pg;
    reg       frc;
    wire      w1 = i_wr && pg == 8'h01;
    // Shadows of page and force bit, so checks know what the host selected
    always @(posedge i_clock) begin
        if (i_rst) begin
            pg  <= 8'h00;
            frc <= 1'b0;
        end else begin
            if (i_wr && i_addr == 8'h00) pg <= i_wdata;
            if (w1 && i_addr == 8'h2e) frc <= i_wdata[3];
        end
    end
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_rst);
    spk_mute_a: assert property (w1 && i_addr == 8'h2a |-> ##2
        o_speaker_unmute == $past(i_wdata[2], 2)) else $error("mute bit not applied");
    hp_line_a: assert property (w1 && i_addr == 8'h2c |-> ##2
        o_headphone_output_lineout == $past(i_wdata[2], 2)) else $error("lineout not applied");
    hp_bias_a: assert property (w1 && i_addr == 8'h2c |-> ##2 o_dac_bias_mode ==
        ($past(i_wdata[4:3], 2) == 2'b10 ? 2'b00 : $past(i_wdata[4:3], 2)))
        else $error("bias mode wrong");
    mb_pd_a: assert property (w1 && i_addr == 8'h2e |-> ##2
        o_sw_power_down == $past(i_wdata[7], 2)) else $error("power down not applied");
    bias_off_a: assert property ((i_headset_det_en && !i_headset_present && !frc)[*4]
        |-> o_mic_bias_supply_level == 2'b00) else $error("bias powered without headset");
    rsvd_rd_a: assert property (i_rd && (i_addr == 8'h2b || i_addr == 8'h2d)
        |=> o_rdata == 8'h00) else $error("reserved offset read nonzero");
    page_sel_a: assert property (i_rd && pg != 8'h01 && i_addr == 8'h2e
        |=> o_rdata == 8'h00) else $error("page one visible on other page");
    mb_mask_a: assert property (i_rd && pg == 8'h01 && i_addr == 8'h2e
        |=> (o_rdata & 8'h74) == 8'h00) else $error("reserved bits read nonzero");
    gain_clr_a: assert property (w1 && i_addr == 8'h2a ##2 i_rd && i_addr == 8'h2a
        |=> !o_rdata[0]) else $error("applied flag not cleared");
    cover property (w1 && i_addr == 8'h2a);
    cover property (w1 && i_addr == 8'h2c && i_wdata[4:3] == 2'b10);
    cover property (o_mic_bias_supply_level == 2'b11);
endmodule // odb_monitor

// file: odb_regs.v
`timescale 1ns/10ps
`include "odb_map.vh"
module odb_regs #(
    parameter BASE_CYC = (`ODB_TICK_BASE_NS * `ODB_CLK_KHZ) / 1000000,
    parameter SETTLE   = `ODB_GAIN_SETTLE
) (
    // Clock and reset
    input  wire       i_clock,
    input  wire       i_rst,
    // Register port
    input  wire       i_wr,
    input  wire       i_rd,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    output reg  [7:0] o_rdata,
    // Analog side inputs
    input  wire       i_short_raw,
    input  wire       i_headset_det_en,
    input  wire       i_headset_present,
    input  wire       i_use_osc,
    input  wire [7:0] i_osc_scale,
    // Speaker driver controls
    output reg        o_speaker_unmute,
    output reg  [1:0] o_speaker_gain,
    // Headphone driver controls
    output reg  [1:0] o_dac_bias_mode,
    output reg        o_headphone_output_lineout,
    output reg        o_short_detected,
    // Mic bias controls
    output reg        o_sw_power_down,
    output reg  [1:0] o_mic_bias_supply_level
);
    // Register map on page 1, as seen by the host
    //
    // Offset 0x00 (every page): page select. Any value may be written;
    // only value one opens the three driver registers below. Other
    // pages read back zero at the page-1 offsets and drop writes there.
    //
    // Offset 0x2a, speaker driver control
    //   bits 7..5  reserved, forced to zero on write
    //   bits 4..3  output stage gain step, passed to o_speaker_gain
    //   bit  2     mute release; zero keeps the stage muted
    //   bit  1     reserved, forced to zero on write
    //   bit  0     gain-applied status, read only, never stored
    //
    // Offset 0x2b: reserved, writes dropped, reads zero
    //
    // Offset 0x2c, headphone driver control
    //   bits 7..5  short-circuit debounce code, zero bypasses the filter
    //   bits 4..3  converter bias-current mode; code 10 is not a legal
    //              mode, so a write of it lands as the default mode
    //   bit  2     line-out configuration of the headphone_output stage
    //   bits 1..0  reserved, forced to zero on write
    //
    // Offset 0x2d: reserved, host must leave it alone; writes dropped
    //
    // Offset 0x2e, mic bias control
    //   bit  7     software power-down request
    //   bits 6..4  reserved, forced to zero on write
    //   bit  3     force bias on even with no headset present
    //   bit  2     reserved, forced to zero on write
    //   bits 1..0  mic_bias_supply level: off, 2 V, 2.5 V, analog_supply
    //
    // Timing seen from the register port:
    //   write edge N    register updates
    //   edge N+1        driver control outputs follow
    //   read edge N     o_rdata holds the value from N onward
    //   write and read on one edge return the value before the write
    //
    // Reset state:
    //   all three registers and the page select clear to zero, so the
    //   speaker starts muted, the headphone stage runs as a headphone
    //   driver, the debounce is bypassed and the mic bias is off
    //   the applied flag rises one edge after reset, as no gain is
    //   pending then
    //
    // Short-circuit debounce:
    //   code c above zero gives an interval of 8 ticks, each tick being
    //   BASE_CYC clock cycles shifted left by c - 1
    //   with the oscillator selected, i_osc_scale replaces BASE_CYC, so
    //   the intervals follow the real oscillator rate
    //   a change of code mid-interval acts on the running count, which
    //   can shorten that one interval; set the code while idle
    //
    // Limitations:
    //   the applied flag only models a fixed settle time; a real ramp
    //   would depend on the step size and the current gain
    //   the debounce base must be a whole number of clock cycles, so the
    //   oscillator figures are only as exact as i_osc_scale allows
    //   o_rdata is not cleared between reads; software sees a stale byte
    //   if it samples without a read strobe
    reg  [7:0] page;
    reg  [7:0] spk;
    reg  [7:0] hp;
    reg  [7:0] mb;
    wire       applied;
    wire       short_flt;
    wire       on_page1;
    wire       spk_load;
    reg  [7:0] next_rdata;
    wire       hit_page;
    wire       hit_spk;
    wire       hit_hp;
    wire       hit_mb;
    wire [7:0] hp_store;
    wire [1:0] level_eff;

    // True when the offset matches; used by the write decode only, the read mux compares i_addr directly
    function is_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            is_hit = (addr == ofs);
        end
    endfunction

    // Stored headphone byte: reserved bits cleared, illegal bias code
    // replaced by the default so the converter never sees it
    function [7:0] hp_clean;
        input [7:0] v;
        reg   [7:0] m;
        begin
            m = v & `ODB_HP_WMASK;
            if (m[`ODB_HP_BIAS_HI:`ODB_HP_BIAS_LO] == `ODB_HP_BIAS_RSV) begin
                m[`ODB_HP_BIAS_HI:`ODB_HP_BIAS_LO] = `ODB_HP_BIAS_DEF;
            end
            hp_clean = m;
        end
    endfunction

    // Effective bias level: held off while detection sees no headset,
    // unless the force bit overrides the detector
    function [1:0] bias_level;
        input [7:0] v;
        input       det_en;
        input       present;
        begin
            if (!v[`ODB_MB_FORCE] && det_en && !present) begin
                bias_level = `ODB_MB_LVL_OFF;
            end else begin
                bias_level = v[`ODB_MB_LVL_HI:`ODB_MB_LVL_LO];
            end
        end
    endfunction

    // Driver register hits only count while page 1 is selected; the page select hit is not gated
    assign on_page1  = (page == `ODB_PAGE_ONE);
    assign hit_page  = is_hit(i_addr, `ODB_PAGE_OFS);
    assign hit_spk   = on_page1 && is_hit(i_addr, `ODB_SPK_OFS);
    assign hit_hp    = on_page1 && is_hit(i_addr, `ODB_HP_OFS);
    assign hit_mb    = on_page1 && is_hit(i_addr, `ODB_MB_OFS);
    assign spk_load  = i_wr && hit_spk;
    assign hp_store  = hp_clean(i_wdata);
    assign level_eff = bias_level(mb, i_headset_det_en, i_headset_present);

    // Writes; reserved bits are masked so they always hold zero
    always @(posedge i_clock) begin
        if (i_rst) begin
            page <= `ODB_RESET_VAL;
            spk  <= `ODB_RESET_VAL;
            hp   <= `ODB_RESET_VAL;
            mb   <= `ODB_RESET_VAL;
        end else if (i_wr) begin
            // The page select sits at 0x00 on every page, so it is
            // decoded ahead of the page gate
            if (hit_page) begin
                page <= i_wdata;
            end else if (on_page1) begin
                case (i_addr)
                    `ODB_SPK_OFS: begin
                        spk <= i_wdata & `ODB_SPK_WMASK;
                    end
                    `ODB_HP_OFS: begin
                        // Illegal bias code is replaced before it is stored
                        hp <= hp_store;
                    end
                    `ODB_MB_OFS: begin
                        mb <= i_wdata & `ODB_MB_WMASK;
                    end
                    default: begin
                        page <= page; // Reserved offsets, incl. 0x2d, ignore writes
                    end
                endcase
            end
        end
    end

    // Gain-applied tracker for the speaker stage; any write to the
    // speaker register counts as a new gain, even if the field is
    // unchanged, which errs on the side of reporting pending
    odb_gain_ramp #(
        .SETTLE    (SETTLE)
    ) u_ramp (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_load    (spk_load),
        .o_applied (applied)
    );

    // Short-circuit debounce filter; the code is taken live from the
    // register, so no copy of it needs to be kept here
    odb_debounce #(
        .BASE_CYC    (BASE_CYC)
    ) u_deb (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_code      (hp[`ODB_HP_DEB_HI:`ODB_HP_DEB_LO]),
        .i_osc_scale (i_osc_scale),
        .i_use_osc   (i_use_osc),
        .i_short_raw (i_short_raw),
        .o_short     (short_flt)
    );

    // Read mux; reserved and unknown offsets read as zero
    always @* begin
        next_rdata = `ODB_RESET_VAL;
        if (i_addr == `ODB_PAGE_OFS) begin
            next_rdata = page;
        end else if (on_page1) begin
            case (i_addr)
                `ODB_SPK_OFS: next_rdata = spk | {7'h00, applied};
                `ODB_HP_OFS:  next_rdata = hp;
                `ODB_MB_OFS:  next_rdata = mb;
                default:      next_rdata = `ODB_RESET_VAL;
            endcase
        end
    end

    // Read data register; holds between strobes so a slow host can
    // sample it late
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata <= `ODB_RESET_VAL;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    // Speaker stage controls; muted out of reset
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_speaker_unmute <= 1'b0;
            o_speaker_gain   <= 2'h0;
        end else begin
            o_speaker_unmute <= spk[`ODB_SPK_UNMUTE];
            o_speaker_gain   <= spk[`ODB_SPK_GAIN_HI:`ODB_SPK_GAIN_LO];
        end
    end

    // Headphone stage controls and the filtered short flag
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_dac_bias_mode            <= 2'h0;
            o_headphone_output_lineout <= 1'b0;
            o_short_detected           <= 1'b0;
        end else begin
            o_dac_bias_mode            <= hp[`ODB_HP_BIAS_HI:`ODB_HP_BIAS_LO];
            o_headphone_output_lineout <= hp[`ODB_HP_LINEOUT];
            o_short_detected           <= short_flt;
        end
    end

    // Mic bias controls; the level is recomputed every cycle, so a
    // headset arriving or leaving takes effect one edge later
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_sw_power_down         <= 1'b0;
            o_mic_bias_supply_level <= 2'h0;
        end else begin
            o_sw_power_down         <= mb[`ODB_MB_SWPD];
            o_mic_bias_supply_level <= level_eff;
        end
    end
endmodule // odb_regs

// file: odb_tb.sv
`timescale 1ns/10ps
module testbench;
    reg        i_clock = 1'b0;
    reg        i_rst = 1'b1;
    reg        i_wr = 1'b0;
    reg        i_rd = 1'b0;
    reg  [7:0] i_addr = 8'h00;
    reg  [7:0] i_wdata = 8'h00;
    reg        i_short_raw = 1'b0;
    reg        i_headset_det_en = 1'b0;
    reg        i_headset_present = 1'b0;
    reg        i_use_osc = 1'b0;
    reg  [7:0] i_osc_scale = 8'h00;
    wire [7:0] o_rdata;
    wire       o_speaker_unmute;
    wire [1:0] o_speaker_gain;
    wire [1:0] o_dac_bias_mode;
    wire       o_headphone_output_lineout;
    wire       o_short_detected;
    wire       o_sw_power_down;
    wire [1:0] o_mic_bias_supply_level;
    integer    seed = 69731;
    integer    n_mismatch = 0;
    integer    comparisons = 0;
    integer    k;
    reg  [7:0] d;
    reg  [7:0] e;
    // One-cycle debounce base keeps the run short; settle shortened too
    odb_regs #(
        .BASE_CYC (1),
        .SETTLE   (4)
    ) uut (
        .i_clock                    (i_clock),
        .i_rst                      (i_rst),
        .i_wr                       (i_wr),
        .i_rd                       (i_rd),
        .i_addr                     (i_addr),
        .i_wdata                    (i_wdata),
        .o_rdata                    (o_rdata),
        .i_short_raw                (i_short_raw),
        .i_headset_det_en           (i_headset_det_en),
        .i_headset_present          (i_headset_present),
        .i_use_osc                  (i_use_osc),
        .i_osc_scale                (i_osc_scale),
        .o_speaker_unmute           (o_speaker_unmute),
        .o_speaker_gain             (o_speaker_gain),
        .o_dac_bias_mode            (o_dac_bias_mode),
        .o_headphone_output_lineout (o_headphone_output_lineout),
        .o_short_detected           (o_short_detected),
        .o_sw_power_down            (o_sw_power_down),
        .o_mic_bias_supply_level    (o_mic_bias_supply_level)
    );
    initial forever #50 i_clock = ~i_clock;
    task tk(input integer n); repeat (n) @(posedge i_clock); #1; endtask
    task wr(input [7:0] a, input [7:0] v);
        @(posedge i_clock); i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
        @(posedge i_clock); i_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge i_clock); i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock); i_rd <= 1'b0; #1;
    endtask
    task chk(input [7:0] s, input [7:0] x, input [95:0] n);
        comparisons = comparisons + 1;
        if (s !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s expected %h seen %h", n, x, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reserved bias code 10 is refused and stored as 00
    function [7:0] hp_e(input [7:0] v);
        hp_e = v;
        if (v[4:3] == 2'b10) hp_e[4:3] = 2'b00;
    endfunction
    function [1:0] mb_e(input [7:0] v);
        mb_e = (i_headset_det_en && !i_headset_present && !v[3]) ? 2'b00 : v[1:0];
    endfunction
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(8'h2a); chk(o_rdata, 8'h00, "page0");
        rd(8'h2e); chk(o_rdata, 8'h00, "page0mb");
        wr(8'h00, 8'h01);
        rd(8'h2d); chk(o_rdata, 8'h00, "rsvd");
        chk(8'(o_speaker_unmute), 8'h00, "mute0");
        // Every bias code in turn, other fields random
        for (k = 0; k < 8; k = k + 1) begin
            d = $random(seed) & 8'hfc;
            d[4:3] = k[1:0];
            e = hp_e(d);
            wr(8'h2c, d); tk(2);
            chk(8'(o_dac_bias_mode), 8'(e[4:3]), "bias");
            chk(8'(o_headphone_output_lineout), 8'(d[2]), "line");
            rd(8'h2c); chk(o_rdata, e, "hp");
            d = $random(seed) & 8'h8b;
            {i_headset_det_en, i_headset_present} <= 2'($random(seed));
            wr(8'h2e, d); tk(2);
            chk(8'(o_sw_power_down), 8'(d[7]), "swpd");
            chk(8'(o_mic_bias_supply_level), 8'(mb_e(d)), "level");
            d = $random(seed) & 8'h1c;
            wr(8'h2a, d); rd(8'h2a); chk(o_rdata, d, "pending");
            chk(8'(o_speaker_unmute), 8'(d[2]), "unmute");
            chk(8'(o_speaker_gain), 8'(d[4:3]), "gain");
            tk(6); rd(8'h2a); chk(o_rdata, d | 8'h01, "applied");
        end
        wr(8'h00, 8'h00); wr(8'h2a, d ^ 8'h04); wr(8'h00, 8'h01);
        rd(8'h2a); chk(o_rdata, d | 8'h01, "pagewr");
        wr(8'h2c, 8'h20); i_short_raw <= 1'b1; tk(3);
        chk(8'(o_short_detected), 8'h00, "deb_early");
        tk(20); chk(8'(o_short_detected), 8'h01, "deb_late");
        wr(8'h2c, 8'h00); i_short_raw <= 1'b0; tk(4);
        chk(8'(o_short_detected), 8'h00, "deb_zero");
        // Oscillator base of two cycles doubles every interval
        i_use_osc <= 1'b1; i_osc_scale <= 8'h02;
        wr(8'h2c, 8'h20); i_short_raw <= 1'b1; tk(12);
        chk(8'(o_short_detected), 8'h00, "osc_early");
        tk(10); chk(8'(o_short_detected), 8'h01, "osc_late");
        report_and_stop;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #1000000;
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
endmodule // testbench
bind odb_regs odb_monitor mon (.*);
